/* hw/pcsc_top.sv */
// primary cache status, control and error capture
`timescale 1ns/1ps
module pcsc_top
    import pcsc_pkg::*;
(
    input wire logic clk, // processor clock
    input wire logic srst, // sync reset, active high
    input pcsc_req_t req, // register move request
    output logic [31:0] rdata, // read data, valid the cycle after rd
    input pcsc_err_t err, // error event
    input pcsc_ref_t ref_in, // reference lookup
    input wire logic nop_cycle, // no-operation cycle
    output logic hit, // reference hit
    output logic cacheable, // reference may be cached
    output logic tag_par_en, // tag parity reportable
    output logic data_par_en, // data parity reportable
    output logic flush_all, // clear all valid bits pulse
    output logic refresh_req, // refresh one row pulse
    output logic cache_active // cache effectively enabled
);
    logic first_error_trap_flag_r; // first error trap flag
    logic nested_error_trap_flag_r; // nested error trap flag
    logic intr_r; // error interrupt flag
    logic hit_r; // latched hit result
    logic refr_r; // refresh allow
    logic flush_r; // invalidate pulse
    logic en_r; // cache enable bit
    logic fhit_r; // force-hit bit
    logic [4:0] etype_r; // error type bits
    logic [29:0] addr_r; // captured error address
    logic wr_sts; // status write strobe
    logic wr_err; // address register write strobe
    logic locked; // interrupt-class type capture frozen
    logic mchk; // machine-check event
    logic ierr; // interrupt-class event
    logic [PCSC_CNT_W-1:0] cnt; // refresh counter
    logic [PCSC_TMR_W-1:0] tmr; // refresh timer
    logic [31:0] sts_view; // status read value
    logic [31:0] err_view; // address register read value

    assign wr_sts = req.wr && (req.idx == PCSC_IDX_STATUS);
    assign wr_err = req.wr && (req.idx == PCSC_IDX_ERR_ADDR);
    assign mchk = err.valid && (err.cls == PCSC_ERR_MCHK);
    assign ierr = err.valid && (err.cls == PCSC_ERR_INTR);
    assign locked = first_error_trap_flag_r || intr_r;

    // first trap: set wins over software clear
    always_ff @(posedge clk) begin
        if (srst) begin
            first_error_trap_flag_r <= 1'b0;
        end else if (mchk && !first_error_trap_flag_r) begin
            first_error_trap_flag_r <= 1'b1;
        end else if (wr_sts && req.wdata[PCSC_B_FIRST_ERROR_TRAP_FLAG]) begin
            first_error_trap_flag_r <= 1'b0;
        end
    end

    // nested trap: machine check while first trap set
    always_ff @(posedge clk) begin
        if (srst) begin
            nested_error_trap_flag_r <= 1'b0;
        end else if (mchk && first_error_trap_flag_r) begin
            nested_error_trap_flag_r <= 1'b1;
        end else if (wr_sts && req.wdata[PCSC_B_NESTED_ERROR_TRAP_FLAG]) begin
            nested_error_trap_flag_r <= 1'b0;
        end
    end

    // interrupt flag: set wins over clear
    always_ff @(posedge clk) begin
        if (srst) begin
            intr_r <= 1'b0;
        end else if (ierr) begin
            intr_r <= 1'b1;
        end else if (wr_sts && req.wdata[PCSC_B_INTR]) begin
            intr_r <= 1'b0;
        end
    end

    // error type capture with lock
    always_ff @(posedge clk) begin
        if (srst) begin
            etype_r <= PCSC_ETYPE_RST;
        end else if (mchk && !first_error_trap_flag_r) begin
            etype_r <= err.etype;
        end else if (ierr && !locked) begin
            etype_r <= err.etype;
        end
    end

    // error address capture on first trap, zero for writes
    always_ff @(posedge clk) begin
        if (srst) begin
            addr_r <= PCSC_ADDR_RST;
        end else if (mchk && !first_error_trap_flag_r) begin
            // writes carry no usable address
            addr_r <= err.is_read ? err.addr : PCSC_ADDR_RST;
        end
    end

    // control bits written by software
    always_ff @(posedge clk) begin
        if (srst) begin
            en_r <= 1'b0;
            fhit_r <= 1'b0;
            refr_r <= 1'b0;
        end else if (wr_sts) begin
            en_r <= req.wdata[PCSC_B_EN];
            fhit_r <= req.wdata[PCSC_B_FHIT];
            refr_r <= req.wdata[PCSC_B_REFR];
        end
    end

    // invalidate-all self clears after one cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            flush_r <= 1'b0;
        end else begin
            flush_r <= wr_sts && req.wdata[PCSC_B_FLUSH];
        end
    end

    // hit latch on data-stream cycles
    always_ff @(posedge clk) begin
        if (srst) begin
            hit_r <= 1'b0;
        end else if (ref_in.valid && ref_in.dstream) begin
            hit_r <= hit;
        end
    end

    // any error flag disables the cache; enable bit kept
    assign cache_active = en_r && !first_error_trap_flag_r && !nested_error_trap_flag_r && !intr_r;
    assign flush_all = flush_r;

    pcsc_lookup u_lookup (
        .ref_in(ref_in),
        .cache_on(cache_active),
        .force_hit(fhit_r),
        .hit(hit),
        .cacheable(cacheable),
        .tag_par_en(tag_par_en),
        .data_par_en(data_par_en)
    );

    pcsc_refresh u_refresh (
        .clk(clk),
        .srst(srst),
        .enable(refr_r),
        .nop_cycle(nop_cycle),
        .load(wr_err),
        .wdata(req.wdata),
        .cnt(cnt),
        .tmr(tmr),
        .refresh_req(refresh_req)
    );

    // read views; flush bit always zero
    always_comb begin
        sts_view = 32'h00000000;
        sts_view[PCSC_ETYPE_HI:PCSC_ETYPE_LO] = etype_r;
        sts_view[PCSC_B_FIRST_ERROR_TRAP_FLAG] = first_error_trap_flag_r;
        sts_view[PCSC_B_NESTED_ERROR_TRAP_FLAG] = nested_error_trap_flag_r;
        sts_view[PCSC_B_INTR] = intr_r;
        sts_view[PCSC_B_HIT] = hit_r;
        sts_view[PCSC_B_REFR] = refr_r;
        sts_view[PCSC_B_EN] = en_r;
        sts_view[PCSC_B_FHIT] = fhit_r;
        err_view = 32'h00000000;
        if (first_error_trap_flag_r) begin
            err_view[PCSC_ADDR_W-1:0] = addr_r;
        end else begin
            err_view[PCSC_TMR_HI:PCSC_TMR_LO] = tmr;
            err_view[PCSC_CNT_HI:PCSC_CNT_LO] = cnt;
        end
    end

    // registered read data for read moves
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 32'h00000000;
        end else if (req.rd) begin
            case (req.idx)
                PCSC_IDX_STATUS: begin
                    rdata <= sts_view;
                end
                PCSC_IDX_ERR_ADDR: begin
                    rdata <= err_view;
                end
                default: begin
                    rdata <= 32'h00000000;
                end
            endcase
        end
    end

    AST_FIRST_ERROR_TRAP_FLAG_SET: assert property (@(posedge clk) disable iff (srst)
        mchk |=> first_error_trap_flag_r)
        else $error("machine check did not set first trap");
    AST_ADDR_FROZEN: assert property (@(posedge clk) disable iff (srst)
        first_error_trap_flag_r && $past(first_error_trap_flag_r) |-> $stable(addr_r) && $stable(etype_r))
        else $error("capture changed while locked");
    AST_NESTED_ERROR_TRAP_FLAG_SET: assert property (@(posedge clk) disable iff (srst)
        mchk && first_error_trap_flag_r |=> nested_error_trap_flag_r && first_error_trap_flag_r)
        else $error("nested trap not set");
    AST_DISABLE: assert property (@(posedge clk) disable iff (srst)
        (first_error_trap_flag_r || nested_error_trap_flag_r || intr_r) |-> !cache_active)
        else $error("cache active with error flag");
    AST_EN_KEPT: assert property (@(posedge clk) disable iff (srst)
        !wr_sts |=> $stable(en_r))
        else $error("enable bit changed without write");
    AST_CLEAR: assert property (@(posedge clk) disable iff (srst)
        wr_sts && req.wdata[PCSC_B_INTR] && !ierr |=> !intr_r)
        else $error("interrupt flag not cleared");
    AST_INTR_SET: assert property (@(posedge clk) disable iff (srst)
        ierr |=> intr_r)
        else $error("interrupt error not flagged");
    AST_FLUSH_PULSE: assert property (@(posedge clk) disable iff (srst)
        flush_all |=> !flush_all || $past(wr_sts))
        else $error("flush did not self clear");
    AST_MISS_OFF: assert property (@(posedge clk) disable iff (srst)
        !cache_active && !fhit_r |-> !hit)
        else $error("hit while cache disabled");
    AST_FHIT: assert property (@(posedge clk) disable iff (srst)
        fhit_r && ref_in.valid && !ref_in.io_space |-> hit)
        else $error("force hit missed");
    AST_VIEW: assert property (@(posedge clk) disable iff (srst)
        req.rd && req.idx == PCSC_IDX_ERR_ADDR && !first_error_trap_flag_r
        |=> rdata[31:16] == 16'h0000 && rdata[2:0] == 3'h0)
        else $error("refresh view reserved bits set");

    // flag clears by one-write, unless the same cycle sets them
    AST_FIRST_ERROR_TRAP_FLAG_CLR: assert property (@(posedge clk) disable iff (srst)
        wr_sts && req.wdata[PCSC_B_FIRST_ERROR_TRAP_FLAG] && !mchk |=> !first_error_trap_flag_r)
        else $error("first trap not cleared");
    AST_NESTED_ERROR_TRAP_FLAG_CLR: assert property (@(posedge clk) disable iff (srst)
        wr_sts && req.wdata[PCSC_B_NESTED_ERROR_TRAP_FLAG] && !(mchk && first_error_trap_flag_r) |=> !nested_error_trap_flag_r)
        else $error("nested trap not cleared");

    // capture of error type and address, and its lock
    AST_MCHK_CAPT: assert property (@(posedge clk) disable iff (srst)
        mchk && !first_error_trap_flag_r |=> etype_r == $past(err.etype))
        else $error("machine check type not captured");
    AST_INTR_CAPT: assert property (@(posedge clk) disable iff (srst)
        ierr && !locked |=> etype_r == $past(err.etype))
        else $error("interrupt type not captured");
    AST_INTR_LOCK: assert property (@(posedge clk) disable iff (srst)
        ierr && locked |=> $stable(etype_r))
        else $error("locked error type overwritten");
    AST_ADDR_CAPT: assert property (@(posedge clk) disable iff (srst)
        mchk && !first_error_trap_flag_r && err.is_read |=> addr_r == $past(err.addr))
        else $error("failing read address not captured");

    // hit latch, lookup, parity gating and flush pulse
    AST_HIT_LATCH: assert property (@(posedge clk) disable iff (srst)
        ref_in.valid && ref_in.dstream && !ref_in.io_space
            && ref_in.tag_match && cache_active |=> hit_r)
        else $error("hit latch missed a data-stream hit");
    AST_HIT_HOLD: assert property (@(posedge clk) disable iff (srst)
        !(ref_in.valid && ref_in.dstream) |=> $stable(hit_r))
        else $error("hit latch moved without data-stream cycle");
    AST_NO_IO: assert property (@(posedge clk) disable iff (srst)
        ref_in.valid && ref_in.io_space |-> !cacheable && !hit)
        else $error("I/O reference cached");
    AST_PAR_OFF: assert property (@(posedge clk) disable iff (srst)
        fhit_r && ref_in.dstream |-> !tag_par_en && !data_par_en)
        else $error("parity reported under force hit");
    AST_PAR_ON: assert property (@(posedge clk) disable iff (srst)
        cache_active && !fhit_r && !ref_in.is_write
        |-> tag_par_en && data_par_en)
        else $error("parity not reportable with cache on");
    AST_FLUSH_SET: assert property (@(posedge clk) disable iff (srst)
        wr_sts && req.wdata[PCSC_B_FLUSH] |=> flush_all)
        else $error("invalidate write gave no flush");

    // read views
    AST_ERR_VIEW: assert property (@(posedge clk) disable iff (srst)
        req.rd && req.idx == PCSC_IDX_ERR_ADDR && first_error_trap_flag_r
        |=> rdata == {2'h0, $past(addr_r)})
        else $error("error address view wrong");
    AST_STS_VIEW: assert property (@(posedge clk) disable iff (srst)
        req.rd && req.idx == PCSC_IDX_STATUS
        |=> rdata[31:13] == 19'h00000 && !rdata[PCSC_B_FLUSH])
        else $error("status view reserved or flush bit set");
    CVR_MCHK: cover property (@(posedge clk) disable iff (srst) mchk);
    CVR_INTR_LOCK: cover property (@(posedge clk) disable iff (srst)
        ierr && locked);
    CVR_NEST: cover property (@(posedge clk) disable iff (srst)
        mchk && first_error_trap_flag_r);
    CVR_INTR: cover property (@(posedge clk) disable iff (srst) ierr);
    CVR_FLUSH: cover property (@(posedge clk) disable iff (srst) flush_all);
endmodule

/* include/pcsc_pkg.sv */
// package: register numbers, field positions and carrier types
package pcsc_pkg;
    // internal register numbers (index space of the register moves)
    localparam logic [7:0] PCSC_IDX_ERR_ADDR = 8'h7E; // error address view
    localparam logic [7:0] PCSC_IDX_STATUS = 8'h7B; // status/control number
    // status field positions
    localparam int PCSC_B_FIRST_ERROR_TRAP_FLAG = 7;
    localparam int PCSC_B_NESTED_ERROR_TRAP_FLAG = 6;
    localparam int PCSC_B_INTR = 5;
    localparam int PCSC_B_HIT = 4;
    localparam int PCSC_B_REFR = 3;
    localparam int PCSC_B_FLUSH = 2;
    localparam int PCSC_B_EN = 1;
    localparam int PCSC_B_FHIT = 0;
    localparam int PCSC_ETYPE_LO = 8;
    localparam int PCSC_ETYPE_HI = 12;
    // refresh view field positions
    localparam int PCSC_CNT_LO = 3;
    localparam int PCSC_CNT_HI = 8;
    localparam int PCSC_TMR_LO = 9;
    localparam int PCSC_TMR_HI = 15;
    localparam int PCSC_CNT_W = 6;
    localparam int PCSC_TMR_W = 7;
    localparam int PCSC_ADDR_W = 30;
    // reset values
    localparam logic [4:0] PCSC_ETYPE_RST = 5'h00;
    localparam logic [5:0] PCSC_CNT_RST = 6'h00;
    localparam logic [6:0] PCSC_TMR_RST = 7'h00;
    localparam logic [29:0] PCSC_ADDR_RST = 30'h00000000;
    // error report class
    typedef enum logic [1:0] {
        PCSC_ERR_NONE = 2'h0,
        PCSC_ERR_MCHK = 2'h1,
        PCSC_ERR_INTR = 2'h2
    } pcsc_class_t;
    // error event from the core pipeline
    typedef struct packed {
        logic valid;           // error event this cycle
        pcsc_class_t cls;      // machine check or interrupt
        logic [4:0] etype;     // error type bits 12..8
        logic is_read;         // failing reference was a read
        logic [29:0] addr;     // physical address of reference
    } pcsc_err_t;
    // register move request
    typedef struct packed {
        logic wr;              // register write move
        logic rd;              // register read move
        logic [7:0] idx;       // register number
        logic [31:0] wdata;    // write data
    } pcsc_req_t;
    // reference lookup from the pipeline
    typedef struct packed {
        logic valid;           // reference this cycle
        logic dstream;         // data-stream reference
        logic io_space;        // I/O space reference
        logic is_write;        // write reference
        logic tag_match;       // raw tag comparator output
    } pcsc_ref_t;
endpackage

/* hw/pcsc_refresh.sv */
// refresh counter and timer
`timescale 1ns/1ps
module pcsc_refresh
    import pcsc_pkg::*;
(
    input wire logic clk, // processor clock
    input wire logic srst, // sync reset
    input wire logic enable, // refresh allowed
    input wire logic nop_cycle, // no-operation cycle
    input wire logic load, // write to error address register
    input wire logic [31:0] wdata, // write data
    output logic [PCSC_CNT_W-1:0] cnt, // refresh counter
    output logic [PCSC_TMR_W-1:0] tmr, // refresh timer
    output logic refresh_req // refresh one row this cycle
);
    logic [PCSC_CNT_W-1:0] cnt_r; // counter state
    logic [PCSC_TMR_W-1:0] tmr_r; // timer state
    logic tick_r; // timer wrap pulse

    // counter: load wins, else advance on no-ops
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_r <= PCSC_CNT_RST;
        end else if (load) begin
            cnt_r <= wdata[PCSC_CNT_HI:PCSC_CNT_LO];
        end else if (enable && nop_cycle) begin
            cnt_r <= cnt_r + 6'h01;
        end
    end

    // timer: advances on other cycles, stops when disabled
    always_ff @(posedge clk) begin
        if (srst) begin
            tmr_r <= PCSC_TMR_RST;
            tick_r <= 1'b0;
        end else if (load) begin
            tmr_r <= wdata[PCSC_TMR_HI:PCSC_TMR_LO];
            tick_r <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            if (enable && !nop_cycle) begin
                tmr_r <= tmr_r + 7'h01;
                tick_r <= (tmr_r == 7'h7F);
            end
        end
    end

    assign cnt = cnt_r;
    assign tmr = tmr_r;
    assign refresh_req = tick_r & enable;

    AST_HOLD: assert property (@(posedge clk) disable iff (srst)
        !enable && !load |=> $stable(cnt_r) && $stable(tmr_r))
        else $error("refresh state moved while disabled");
    AST_LOAD: assert property (@(posedge clk) disable iff (srst)
        load |=> cnt_r == $past(wdata[PCSC_CNT_HI:PCSC_CNT_LO])
            && tmr_r == $past(wdata[PCSC_TMR_HI:PCSC_TMR_LO]))
        else $error("refresh load mismatch");
endmodule

/* hw/pcsc_lookup.sv */
// hit/miss qualification and parity report gating
`timescale 1ns/1ps
module pcsc_lookup
    import pcsc_pkg::*;
(
    input pcsc_ref_t ref_in, // reference from pipeline
    input wire logic cache_on, // effective cache enable
    input wire logic force_hit, // force-hit control
    output logic hit, // reference hits
    output logic cacheable, // reference may be filled
    output logic tag_par_en, // tag parity reportable
    output logic data_par_en // data parity reportable
);
    // combinational lookup qualification
    always_comb begin
        cacheable = ref_in.valid && !ref_in.io_space && cache_on;
        if (!ref_in.valid || ref_in.io_space) begin
            hit = 1'b0;
        end else if (force_hit) begin
            hit = 1'b1;
        end else if (!cache_on) begin
            hit = 1'b0;
        end else begin
            hit = ref_in.tag_match;
        end
        tag_par_en = cache_on && !(force_hit && ref_in.dstream);
        data_par_en = cache_on && !(force_hit && ref_in.dstream)
            && !ref_in.is_write;
    end
endmodule

/* tb/pcsc_core_model.sv */
// core-side model issuing register moves
`timescale 1ns/1ps
module pcsc_core_model
    import pcsc_pkg::*;
(
    input wire logic clk, // processor clock
    output pcsc_req_t req, // register move request
    input wire logic [31:0] rdata // registered read data
);
    initial req = '0; // idle at time zero

    // one write move, held up to its sampling edge
    task automatic wr_reg(input logic [7:0] idx, input logic [31:0] v);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, idx: idx, wdata: v};
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b0, idx: ~idx, wdata: ~v};
    endtask

    // one read move, data taken after the answering edge
    task automatic rd_reg(input logic [7:0] idx, output logic [31:0] v);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, idx: idx, wdata: ~req.wdata};
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b0, idx: ~idx, wdata: ~req.wdata};
        #1 v = rdata;
    endtask

    // invalidate and enable in the same move
    task automatic enable_cache();
        wr_reg(PCSC_IDX_STATUS, 32'h00000006);
    endtask

    // force-hit only with the cache enabled
    task automatic set_force();
        wr_reg(PCSC_IDX_STATUS, 32'h00000003);
    endtask
endmodule

/* tb/tb.sv */
// testbench for cache status, control and error capture
`timescale 1ns/1ps
module tb;
    import pcsc_pkg::*;
    logic clk = 1'b0; // processor clock
    logic srst = 1'b1; // sync reset
    pcsc_req_t req; // register move
    logic [31:0] rdata; // read data
    pcsc_err_t err = '0; // error event
    pcsc_ref_t ref_in = '0; // reference
    logic nop_cycle = 1'b0; // no-op cycle
    logic hit; // lookup outputs
    logic cacheable;
    logic tag_par_en;
    logic data_par_en;
    logic flush_all; // invalidate pulse
    logic refresh_req; // refresh pulse
    logic cache_active; // effective enable
    int error_cnt = 0; // mismatches
    int check_count = 0; // comparisons
    logic [31:0] d; // read value
    logic [29:0] a; // random address
    logic [4:0] et; // random error type
    logic [4:0] e2; // second error type
    logic seen; // refresh pulse seen
    logic [31:0] ea; // expected address view
    localparam logic [31:0] FULL = 32'hFFFFFFFF; // compare every bit
    localparam logic [31:0] NOHIT = 32'hFFFFFFEF; // skip latched hit bit

    always #10 clk = ~clk; // 50 MHz

    pcsc_top dut_u (.clk(clk), .srst(srst), .req(req), .rdata(rdata),
        .err(err), .ref_in(ref_in), .nop_cycle(nop_cycle), .hit(hit),
        .cacheable(cacheable), .tag_par_en(tag_par_en),
        .data_par_en(data_par_en), .flush_all(flush_all),
        .refresh_req(refresh_req), .cache_active(cache_active));

    pcsc_core_model core_u (.clk(clk), .req(req), .rdata(rdata));

    // expected status word
    function automatic logic [31:0] st(input logic [4:0] e,
        input logic [7:0] low);
        return {19'h00000, e, low};
    endfunction

    // compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // read a register and compare the masked value
    task automatic chk_reg(input logic [7:0] idx, input logic [31:0] e,
        input logic [31:0] m);
        core_u.rd_reg(idx, d);
        chk(d & m, e);
    endtask

    // one error event pulse
    task automatic fire(input pcsc_class_t c, input logic [4:0] e,
        input logic r, input logic [29:0] ad);
        @(posedge clk);
        err <= '{valid: 1'b1, cls: c, etype: e, is_read: r, addr: ad};
        @(posedge clk);
        err <= '{valid: 1'b0, cls: PCSC_ERR_NONE, etype: ~e,
            is_read: ~r, addr: ~ad};
        #1;
    endtask

    // one reference, checks hit, cacheable and parity gates
    task automatic look(input pcsc_ref_t r, input logic [3:0] e);
        @(posedge clk);
        ref_in <= r;
        #1 chk({hit, cacheable, tag_par_en, data_par_en}, e);
        @(posedge clk);
        ref_in <= {1'b0, ~r[3:0]};
    endtask

    // verdict and end of run
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        #1000000;
        error_cnt++;
        complete_run();
    end

    // main sequence
    initial begin
        void'($urandom(32'h79E806E9));
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        chk_reg(PCSC_IDX_STATUS, 0, FULL);
        chk_reg(PCSC_IDX_ERR_ADDR, 0, FULL);
        chk(cache_active, 0);
        // unknown register number: write ignored, read zero
        core_u.wr_reg(8'h7D, FULL);
        chk_reg(PCSC_IDX_STATUS, 0, FULL);
        chk_reg(8'h7D, 0, FULL);
        // refresh view load and readback, refresh stopped
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? FULL : $urandom;
            core_u.wr_reg(PCSC_IDX_ERR_ADDR, d);
            ea = d & 32'h0000FFF8;
            chk_reg(PCSC_IDX_ERR_ADDR, ea, FULL);
        end
        // counter runs on no-ops, timer holds
        core_u.wr_reg(PCSC_IDX_ERR_ADDR, 32'h00002028);
        @(posedge clk) nop_cycle <= 1'b1;
        core_u.wr_reg(PCSC_IDX_STATUS, 32'h00000008);
        repeat (5) @(posedge clk);
        core_u.wr_reg(PCSC_IDX_STATUS, 32'h00000000);
        chk_reg(PCSC_IDX_ERR_ADDR, 32'h00002060, 32'hFFFFFFFF);
        // timer runs on other cycles and wraps into a refresh
        @(posedge clk) nop_cycle <= 1'b0;
        core_u.wr_reg(PCSC_IDX_ERR_ADDR, 32'h0000FA18);
        core_u.wr_reg(PCSC_IDX_STATUS, 32'h00000008);
        seen = 1'b0;
        for (int n = 0; n < 20 && !seen; n++) begin
            @(posedge clk);
            #1 if (refresh_req === 1'b1) seen = 1'b1;
        end
        chk(seen, 1);
        core_u.wr_reg(PCSC_IDX_STATUS, 32'h00000000);
        chk_reg(PCSC_IDX_ERR_ADDR, 32'h18, 32'h1F8);
        // flush with enable, flush pulse for one cycle
        core_u.enable_cache();
        #1 chk(flush_all, 1);
        @(posedge clk);
        #1 chk(flush_all, 0);
        chk_reg(PCSC_IDX_STATUS, st(0, 8'h02), 32'hFFFFFFEF);
        chk(cache_active, 1);
        // lookups with the cache enabled, then with it disabled
        look(5'h19, 4'hF);
        chk_reg(PCSC_IDX_STATUS, 32'h10, 32'h10);
        look(5'h18, 4'h7);
        look(5'h11, 4'hF);
        chk_reg(PCSC_IDX_STATUS, 32'h00, 32'h10);
        @(posedge clk) ref_in <= 5'h1D;
        #1 chk(cacheable, 0);
        core_u.set_force();
        look(5'h18, 4'hC);
        look(5'h10, 4'hF);
        core_u.wr_reg(PCSC_IDX_STATUS, 32'h00000000);
        look(5'h19, 4'h0);
        core_u.enable_cache();
        // machine checks, nested ones and address capture
        for (int i = 0; i < 4; i++) begin
            et = 5'($urandom);
            a = 30'($urandom);
            e2 = et ^ 5'h1F;
            ea = (i != 3) ? {2'h0, a} : 32'h00000000;
            fire(PCSC_ERR_MCHK, et, i != 3, a);
            chk(cache_active, 0);
            look(5'h19, 4'h0);
            chk_reg(PCSC_IDX_STATUS, st(et, 8'h82), NOHIT);
            chk_reg(PCSC_IDX_ERR_ADDR, ea, FULL);
            fire(PCSC_ERR_MCHK, e2, 1'b1, ~a);
            chk_reg(PCSC_IDX_STATUS, st(et, 8'hC2), NOHIT);
            chk_reg(PCSC_IDX_ERR_ADDR, ea, FULL);
            core_u.wr_reg(PCSC_IDX_STATUS, 32'h000000C2);
            chk_reg(PCSC_IDX_STATUS, st(et, 8'h02), 32'hFFFFFFEF);
            chk(cache_active, 1);
        end
        // interrupt errors and their capture lock
        fire(PCSC_ERR_INTR, e2, 1'b1, a);
        chk(cache_active, 0);
        chk_reg(PCSC_IDX_STATUS, st(e2, 8'h22), 32'hFFFFFFEF);
        fire(PCSC_ERR_INTR, et, 1'b1, a);
        chk_reg(PCSC_IDX_STATUS, st(e2, 8'h22), 32'hFFFFFFEF);
        fire(PCSC_ERR_MCHK, et, 1'b1, a);
        chk_reg(PCSC_IDX_STATUS, st(et, 8'hA2), 32'hFFFFFFEF);
        core_u.wr_reg(PCSC_IDX_STATUS, 32'h000000E2);
        chk_reg(PCSC_IDX_STATUS, st(et, 8'h02), 32'hFFFFFFEF);
        // reset in mid-run clears the flags
        fire(PCSC_ERR_MCHK, e2, 1'b1, a);
        @(posedge clk) srst <= 1'b1;
        @(posedge clk) srst <= 1'b0;
        chk_reg(PCSC_IDX_STATUS, 0, 32'hFFFFFFFF);
        chk_reg(PCSC_IDX_ERR_ADDR, 0, FULL);
        chk(cache_active, 0);
        complete_run();
    end
endmodule
